// >>> src/lof_pkg.sv
// constants and lookups for the lvds output framer
package lof_pkg;
    // sample clock period is two mclk cycles, so half periods are whole cycles
    localparam int SAMPLE_WIDTH = 12;
    localparam int LINE_DEPTH = 56;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] FRAME_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SINGLE_BIT = 1;
    localparam int CTRL_FOUR_BIT = 2;
    localparam int CTRL_ALIGN_BIT = 3;
    localparam int CTRL_LSB_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [7:0] FRAME_LEN_RESET = 8'h08;
    // least time from a lane request change to the switch
    localparam real LSB_MIN_PERIODS = 26.0;
    localparam int LSB_MIN_HALF = int'(LSB_MIN_PERIODS * 2.0);
    // framing states
    typedef enum logic [1:0] {
        FR_OFF = 2'b01,
        FR_RUN = 2'b10
    } lof_state_type;
    // reference to frame start, in half periods, index {single,four,align}
    function automatic logic [6:0] lof_stb_half(input logic [2:0] mode);
        case (mode)
            3'h3: lof_stb_half = 7'h60;     // 48
            3'h4: lof_stb_half = 7'h5d;     // 46.5
            3'h5: lof_stb_half = 7'h5e;     // 47
            3'h6: lof_stb_half = 7'h5d;     // 46.5
            3'h7: lof_stb_half = 7'h60;     // 48
            default: lof_stb_half = 7'h5e;  // 47
        endcase
    endfunction
    // sampling edge to launching edge, in half periods
    function automatic logic [5:0] lof_dig_half(input logic [2:0] mode);
        case (mode)
            3'h3: lof_dig_half = 6'h36;     // 27
            3'h5: lof_dig_half = 6'h35;     // 26.5
            3'h7: lof_dig_half = 6'h37;     // 27.5
            default: lof_dig_half = 6'h34;  // 26
        endcase
    endfunction
endpackage

// >>> src/lof_framer.sv
// output framer: sample delay, bus arrangement, strobes, ahb-lite registers
// What this block does
// [RULE1] dual: frame starts 47 after reference, 48 aligned-four
// [RULE2] single: 46.5 staggered, 47 aligned-two, 48 aligned-four
// [RULE3] lane request puts strobe on bus b lsb
// [RULE4] lane switch at least 26 periods after change
// [RULE5] aligned four-bus delays earlier samples to latest
// [RULE6] staggered buses start frames at offset times; staggered single four-bus never launches bus d
// [RULE7] strobe marks frame end, next sample starts frame
// [RULE8] three selects choose channel, bus count, alignment
// [RULE9] digital latency 26, 27, 26.5 or 27.5 periods
// [RULE10] single samples on both edges, dual rising only
// [RULE11] captured reference resets the strobe sequence
// [RULE12] frame length fixed while framing runs
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module lof_framer
    import lof_pkg::*;
#(
    parameter int DW = SAMPLE_WIDTH
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic timing_reference,
    input wire logic [DW-1:0] sample_a,
    input wire logic [DW-1:0] sample_b,
    output logic [DW-1:0] bus_a_data,
    output logic [DW-1:0] bus_b_data,
    output logic [DW-1:0] bus_c_data,
    output logic [DW-1:0] bus_d_data,
    output logic bus_a_strobe,
    output logic bus_b_strobe,
    output logic bus_c_strobe,
    output logic bus_d_strobe
);
    logic [1:0] rst_sync;          // reset release chain
    logic rst_n;                   // synchronised reset
    logic [2:0] ref_sync;          // two sync flops plus edge history
    logic ref_edge;                // captured reference rising edge
    // register state
    logic [4:0] ctrl;
    logic [4:0] next_ctrl;
    logic [7:0] frame_len;
    logic [7:0] next_frame_len;
    logic wr_pend;                 // write data phase pending
    logic next_wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic [2:0] mode;              // {single, four, align}
    lof_state_type state;
    lof_state_type next_state;
    // input sampling and delay line
    logic phase;                   // sample clock enable divider
    logic in_valid;
    logic [2*DW:0] line [LINE_DEPTH];
    logic [5:0] tap;
    logic dv;
    logic [DW-1:0] da;
    logic [DW-1:0] db;
    // reference countdown and framing
    logic [6:0] ref_cnt;
    logic [6:0] next_ref_cnt;
    logic realign;
    logic next_realign;
    logic locked;
    logic next_locked;
    logic [1:0] slot;
    logic [1:0] next_slot;
    logic [7:0] pos;
    logic [7:0] next_pos;
    logic [1:0] last_slot;
    logic [1:0] cur_slot;
    logic strobe_flag;             // this group ends the frame
    logic [3:0] span;              // cycles taken by one group of launches
    logic [6:0] ref_load;          // countdown start after a reference
    logic out_ev;
    logic [DW-1:0] pend [4];
    logic [DW-1:0] next_pend [4];
    logic [DW-1:0] bus_data [4];
    logic [DW-1:0] next_bus_data [4];
    logic [3:0] bus_strobe;
    logic [3:0] next_bus_strobe;
    logic [3:0] load;              // which buses launch this cycle
    // lane request tracking
    logic [5:0] lsb_cnt;
    logic [5:0] next_lsb_cnt;
    logic lsb_target;
    logic next_lsb_target;
    logic lsb_active;
    logic next_lsb_active;

    // reset release through two flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // reference pin: two flops before anything looks at it; the history
    // bit moves only on sampling edges, so a dual edge waits to be taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_sync <= 3'h0;
        end else begin
            ref_sync[1:0] <= {ref_sync[0], timing_reference};
            if (ctrl[CTRL_SINGLE_BIT] || !phase) begin
                ref_sync[2] <= ref_sync[1]; // RULE10
            end
        end
    end
    // dual samples the reference on rising sample edges only
    assign ref_edge = ref_sync[1] && !ref_sync[2] && (ctrl[CTRL_SINGLE_BIT]
        || !phase); // RULE10

    assign mode = {ctrl[CTRL_SINGLE_BIT], ctrl[CTRL_FOUR_BIT],
        ctrl[CTRL_ALIGN_BIT]}; // RULE8

    // register bus: zero wait states, hrdata taken from next values so a
    // read right after a write sees the new value
    always_comb begin
        next_ctrl = ctrl;
        next_frame_len = frame_len;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        next_state = ctrl[CTRL_ENABLE_BIT] ? FR_RUN : FR_OFF;
        if (wr_pend) begin
            if (wr_addr == CTRL_OFFSET) begin
                next_ctrl = hwdata[4:0];
            end else if (wr_addr == FRAME_OFFSET && state == FR_OFF) begin
                next_frame_len = hwdata[7:0]; // RULE12
            end
        end
        if (hsel && hready && htrans[1]) begin
            next_wr_pend = hwrite;
            next_wr_addr = haddr[7:0];
            case (haddr[7:0])
                CTRL_OFFSET: next_hrdata = {27'h0, next_ctrl};
                FRAME_OFFSET: next_hrdata = {24'h0, next_frame_len};
                STATUS_OFFSET: next_hrdata = {22'h0, pos, locked,
                    lsb_active};
                default: next_hrdata = 32'h0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            frame_len <= FRAME_LEN_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            state <= FR_OFF;
        end else begin
            ctrl <= next_ctrl;
            frame_len <= next_frame_len;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            state <= next_state;
        end
    end

    // sample enable divider and delay line; single takes every half period
    assign in_valid = (state == FR_RUN) && (ctrl[CTRL_SINGLE_BIT] || !phase);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
            for (int i = 0; i < LINE_DEPTH; i++) begin
                line[i] <= '0;
            end
        end else begin
            phase <= !phase;
            line[0] <= {in_valid, sample_a, sample_b}; // RULE10
            for (int i = 1; i < LINE_DEPTH; i++) begin
                line[i] <= line[i-1];
            end
        end
    end
    // tap sits two short of the latency: one for line[0], one for the bus
    assign tap = lof_dig_half(mode) - 6'h2; // RULE9
    assign {dv, da, db} = line[tap];
    assign out_ev = dv && (state == FR_RUN);
    assign last_slot = {ctrl[CTRL_SINGLE_BIT] & ctrl[CTRL_FOUR_BIT],
        ctrl[CTRL_SINGLE_BIT] ^ ctrl[CTRL_FOUR_BIT]};
    assign cur_slot = realign ? 2'h0 : slot;
    // dual groups take two cycles per slot, single groups one
    assign span = ctrl[CTRL_SINGLE_BIT] ? {2'h0, last_slot} + 4'h1
        : {1'h0, last_slot, 1'b0} + 4'h2;
    // the last group before a realign ends its frame too, so the
    // receiver finds the realigned start behind a strobe
    assign strobe_flag = ((realign ? 8'h0 : pos) == frame_len - 8'h1)
        || (ref_cnt != 7'h0 && ref_cnt <= {3'h0, span}); // RULE7 RULE11
    // take off the launch pipeline and, when aligned, the wait for the
    // latest slot, so the frame starts at the table time
    assign ref_load = lof_stb_half(mode) - 7'h2
        - (ctrl[CTRL_ALIGN_BIT] ? {5'h0, last_slot} : 7'h0);

    // reference countdown, slot and frame position, bus launch
    always_comb begin
        next_ref_cnt = ref_cnt;
        next_realign = realign;
        next_locked = locked;
        next_slot = slot;
        next_pos = pos;
        next_pend = pend;
        next_bus_data = bus_data;
        next_bus_strobe = bus_strobe;
        next_lsb_active = lsb_active;
        load = 4'h0;
        if (out_ev) begin
            next_realign = 1'b0;
            // dual fills a bus pair per word, single one bus per sample
            if (ctrl[CTRL_SINGLE_BIT]) begin
                next_pend[cur_slot] = da;
                load[cur_slot] = 1'b1;
            end else begin
                next_pend[{cur_slot[0], 1'b0}] = da;
                next_pend[{cur_slot[0], 1'b1}] = db;
                load[{cur_slot[0], 1'b0}] = 1'b1;
                load[{cur_slot[0], 1'b1}] = 1'b1;
            end
            if (ctrl[CTRL_ALIGN_BIT] && ctrl[CTRL_FOUR_BIT]) begin
                // hold early samples until the latest one arrives
                load = (cur_slot == last_slot) ? 4'hf : 4'h0; // RULE5
            end else if (ctrl[CTRL_ALIGN_BIT]) begin
                load = (cur_slot == last_slot) ? 4'h3 : 4'h0; // RULE5
            end
            // staggered: each slot launches its own bus (a pair in dual); single four-bus stops at slot 2, so bus d never launches
            for (int i = 0; i < 4; i++) begin
                if (load[i]) begin
                    next_bus_data[i] = next_pend[i]; // RULE6
                    next_bus_strobe[i] = strobe_flag; // RULE7
                end
            end
            // lane switches only at a bus b frame start
            if (load[1] && (realign || pos == 8'h0)) begin
                next_lsb_active = lsb_target; // RULE4
            end
            if (load[1] && next_lsb_active) begin
                next_bus_data[1][0] = strobe_flag; // RULE3
            end
            next_slot = (cur_slot == last_slot) ? 2'h0 : cur_slot + 2'h1;
            if (cur_slot == last_slot) begin
                next_pos = strobe_flag ? 8'h0 : (realign ? 8'h1
                    : pos + 8'h1); // RULE7
            end else if (realign) begin
                next_pos = 8'h0;
            end
        end
        // after the launch so a new realign wins over the launch clear
        if (ref_edge) begin
            next_ref_cnt = ref_load; // RULE1 RULE2
        end else if (ref_cnt != 7'h0) begin
            next_ref_cnt = ref_cnt - 7'h1;
            if (ref_cnt == 7'h1) begin
                next_realign = 1'b1; // RULE11
                next_locked = 1'b1;
            end
        end
        if (state == FR_OFF) begin
            next_slot = 2'h0;
            next_pos = 8'h0;
            next_locked = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt <= 7'h0;
            realign <= 1'b0;
            locked <= 1'b0;
            slot <= 2'h0;
            pos <= 8'h0;
            bus_strobe <= 4'h0;
            lsb_active <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                pend[i] <= '0;
                bus_data[i] <= '0;
            end
        end else begin
            ref_cnt <= next_ref_cnt;
            realign <= next_realign;
            locked <= next_locked;
            slot <= next_slot;
            pos <= next_pos;
            bus_strobe <= next_bus_strobe;
            lsb_active <= next_lsb_active;
            pend <= next_pend;
            bus_data <= next_bus_data;
        end
    end

    // lane request must stand for the least time before it is taken
    always_comb begin
        next_lsb_cnt = 6'h0;
        next_lsb_target = lsb_target;
        if (ctrl[CTRL_LSB_BIT] != lsb_target) begin
            next_lsb_cnt = lsb_cnt + 6'h1;
            if (lsb_cnt == 6'(LSB_MIN_HALF - 1)) begin
                next_lsb_target = ctrl[CTRL_LSB_BIT]; // RULE4
                next_lsb_cnt = 6'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lsb_cnt <= 6'h0;
            lsb_target <= 1'b0;
        end else begin
            lsb_cnt <= next_lsb_cnt;
            lsb_target <= next_lsb_target;
        end
    end

    assign bus_a_data = bus_data[0];
    assign bus_b_data = bus_data[1];
    assign bus_c_data = bus_data[2];
    assign bus_d_data = bus_data[3];
    assign bus_a_strobe = bus_strobe[0];
    assign bus_b_strobe = bus_strobe[1];
    assign bus_c_strobe = bus_strobe[2];
    assign bus_d_strobe = bus_strobe[3];

    // checks on the framing behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_ref_taken;
        ref_edge ##1 (ref_cnt == $past(ref_load));
    endsequence
    a_ref_load_count: assert property (ref_edge |-> s_ref_taken) // RULE1
        else $error("reference countdown not loaded from mode table");
    a_ref_expire_frame: assert property ((ref_cnt == 7'h1 && !ref_edge)
        |=> realign) // RULE11
        else $error("countdown expiry did not realign frame");
    a_single_both_edges: assert property ((state == FR_RUN
        && ctrl[CTRL_SINGLE_BIT]) |-> in_valid) // RULE10
        else $error("single mode missed a half period sample");
    a_dual_rising_only: assert property ((in_valid && !mode[2]
        && $stable(mode)) |=> !in_valid) // RULE10
        else $error("dual mode sampled two half periods in a row");
    a_lsb_least_wait: assert property ($changed(lsb_target)
        |-> $past(lsb_cnt) == 6'(LSB_MIN_HALF - 1)) // RULE4
        else $error("lane switch came before least wait");
    a_lsb_lane_strobe: assert property ((load[1] && next_lsb_active
        && out_ev) |=> bus_b_data[0] == bus_b_strobe) // RULE3
        else $error("bus b lsb does not carry the strobe");
    a_aligned_hold: assert property ((out_ev && mode[1:0] == 2'h3
        && cur_slot != last_slot) |=> $stable(bus_a_data)) // RULE5
        else $error("aligned bus launched before latest sample");
    a_strobe_at_end: assert property ((out_ev && load[0])
        |=> bus_a_strobe == $past(strobe_flag)) // RULE7
        else $error("strobe not tied to frame end");
    a_frame_len_held: assert property ((state == FR_RUN && !wr_pend)
        ##1 (state == FR_RUN) |-> $stable(frame_len)) // RULE12
        else $error("frame length changed while framing");
    a_tap_latency: assert property ((out_ev && !ctrl[CTRL_ALIGN_BIT]
        && load[0]) |=> bus_a_data == $past(da)) // RULE9
        else $error("bus a did not launch the delayed sample");
endmodule // lof_framer

// >>> test/lof_receiver.sv
// receiver model: finds frame starts on buses a and b
`timescale 1ns/100ps
module lof_receiver (
    input wire logic mclk,
    input wire logic [31:0] cyc,
    input wire logic [11:0] a_data,
    input wire logic a_stb,
    input wire logic [11:0] b_data,
    input wire logic b_stb,
    output logic [31:0] a_start,
    output logic [31:0] b_start,
    output logic [31:0] a_size,
    output logic [11:0] a_first,
    output logic [11:0] b_first
);
    logic [11:0] a_q = '0; // last word seen on bus a
    logic [11:0] b_q = '0; // last word seen on bus b
    logic a_sq = 1'b0; // strobe of the previous cycle
    logic b_sq = 1'b0;
    logic [31:0] a_cnt = '0; // launches in the running frame
    // a launch right after a strobe opens a new frame; since the bench
    // feeds a counter, every launch changes the word and can be seen
    always @(posedge mclk) begin
        if (a_sq && a_data !== a_q) begin
            a_start <= cyc;
            a_size <= a_cnt;
            a_cnt <= 32'h1;
            a_first <= a_data;
            b_first <= b_data;
        end else if (a_data !== a_q) begin
            a_cnt <= a_cnt + 32'h1;
        end
        // bus b frame start, to see staggering against bus a
        if (b_sq && b_data !== b_q) begin
            b_start <= cyc;
        end
        a_q <= a_data;
        b_q <= b_data;
        a_sq <= a_stb;
        b_sq <= b_stb;
    end
endmodule // lof_receiver

// >>> test/lvds_output_frame_strobe_timing_tb.sv
// self-checking bench for the lvds output framer
`timescale 1ns/100ps
module lvds_output_frame_strobe_timing_tb;
    import lof_pkg::*;
    typedef struct {
        logic [3:0] ctrl;
        int lat;
        bit stag;
    } lof_row_type;
    // mode rows: control value, reference latency in half periods,
    // staggered single mode (bus b must start apart from bus a)
    lof_row_type rows [8] = '{'{4'h1, 94, 0}, '{4'h9, 94, 0},
        '{4'h5, 94, 0}, '{4'hd, 96, 0}, '{4'h3, 93, 1},
        '{4'hb, 94, 0}, '{4'h7, 93, 1}, '{4'hf, 96, 0}};
    logic mclk = 0;
    logic resetn = 0;
    logic hsel = 0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, timing_reference = 0;
    logic [31:0] hrdata, rdat, cyc = '0;
    logic [11:0] cnt = '0, sample_a = '0, sample_b = '0;
    logic [11:0] bus_a_data, bus_b_data, a_first, b_first;
    logic bus_a_strobe, bus_b_strobe;
    logic [31:0] a_start, b_start, a_size;
    int n_fail = 0;
    int total_checks = 0;
    int t0;
    lof_framer dut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp),
        .timing_reference(timing_reference), .sample_a(sample_a),
        .sample_b(sample_b), .bus_a_data(bus_a_data),
        .bus_b_data(bus_b_data), .bus_c_data(), .bus_d_data(),
        .bus_a_strobe(bus_a_strobe), .bus_b_strobe(bus_b_strobe),
        .bus_c_strobe(), .bus_d_strobe());
    lof_receiver rx (.mclk(mclk), .cyc(cyc), .a_data(bus_a_data),
        .a_stb(bus_a_strobe), .b_data(bus_b_data), .b_stb(bus_b_strobe),
        .a_start(a_start), .b_start(b_start), .a_size(a_size),
        .a_first(a_first), .b_first(b_first));
    always #5 mclk = ~mclk;
    // counter samples make every launch visible; b lsb kept 0 so a
    // strobe placed on that lane cannot hide among data
    always @(posedge mclk) begin
        cnt <= cnt + 12'h1;
        sample_a <= cnt;
        sample_b <= (cnt ^ 12'h800) & 12'hffe;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // cycle count doubles as the hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd20000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, lo, hi, input string m);
        total_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("[ERR] %0t %s got %0d", $time, m, got);
        end
    endtask
    // one single transfer; address held until hready, then data phase
    task automatic ahb(input logic w, input logic [31:0] a, d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // watch bus b lsb for n cycles; want says whether a 1 must show
    task automatic lane_win(input int n, input logic want, input string m);
        int ones;
        ones = 0;
        repeat (n) begin
            @(posedge mclk);
            if (bus_b_data[0] === 1'b1) ones++;
        end
        chk(32'(ones != 0), {31'h0, want}, m);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({31'h0, hreadyout}, 32'h1, "ready");
        chk({31'h0, hresp}, 32'h0, "resp");
        ahb(0, 32'(CTRL_OFFSET), 0, rdat);
        chk(rdat, 32'h0, "ctrl reset");
        ahb(0, 32'(FRAME_OFFSET), 0, rdat);
        chk(rdat, 32'(FRAME_LEN_RESET), "frame reset");
        ahb(1, 32'h0c, 32'hffffffff, rdat);
        ahb(0, 32'h0c, 0, rdat);
        chk(rdat, 32'h0, "unmapped");
        // every mode: reference latency, alignment, frame size
        foreach (rows[i]) begin
            ahb(1, 32'(CTRL_OFFSET), 0, rdat);
            ahb(1, 32'(FRAME_OFFSET), 64, rdat);
            ahb(1, 32'(CTRL_OFFSET), 32'(rows[i].ctrl), rdat);
            repeat (200) @(posedge mclk);
            t0 = int'(cyc);
            timing_reference <= 1'b1;
            repeat (4) @(posedge mclk);
            timing_reference <= 1'b0;
            repeat (rows[i].lat + 4) @(posedge mclk);
            chk_rng(int'(a_start) - t0, rows[i].lat, rows[i].lat + 7,
                "ref latency");
            if (rows[i].ctrl[3] && rows[i].ctrl[1]) begin
                chk({20'h0, b_first}, {20'h0, a_first + 12'h1},
                    "single aligned");
            end else if (rows[i].ctrl[3]) begin
                chk({20'h0, b_first}, {20'h0, (a_first ^ 12'h800) &
                    12'hffe}, "dual aligned");
            end
            if (rows[i].stag) begin
                chk(32'(b_start !== a_start), 32'h1, "stagger");
            end
            repeat (800) @(posedge mclk);
            chk(a_size, 32'd64, "frame size");
        end
        // lane request on dual two-bus, frame of four groups
        ahb(1, 32'(CTRL_OFFSET), 0, rdat);
        ahb(1, 32'(FRAME_OFFSET), 4, rdat);
        ahb(1, 32'(CTRL_OFFSET), 1, rdat);
        repeat (60) @(posedge mclk);
        ahb(1, 32'(CTRL_OFFSET), 32'h11, rdat);
        ahb(1, 32'(FRAME_OFFSET), 32'h20, rdat);
        ahb(0, 32'(FRAME_OFFSET), 0, rdat);
        chk(rdat, 32'h4, "frame locked");
        lane_win(44, 0, "lane early");
        repeat (30) @(posedge mclk);
        lane_win(16, 1, "lane strobe");
        ahb(0, 32'(STATUS_OFFSET), 0, rdat);
        chk({31'h0, rdat[0]}, 32'h1, "lane status");
        ahb(1, 32'(CTRL_OFFSET), 1, rdat);
        lane_win(44, 1, "lane late");
        repeat (30) @(posedge mclk);
        lane_win(16, 0, "lane data");
        // second reset in mid-run
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({19'h0, bus_a_strobe, bus_a_data}, 32'h0, "reset out");
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        ahb(0, 32'(CTRL_OFFSET), 0, rdat);
        chk(rdat, 32'h0, "ctrl after reset");
        final_report;
    end
endmodule // lvds_output_frame_strobe_timing_tb
